// ---- bench/pdf_chk.sv ----
// checker: port level properties of the pwm timer top
`timescale 1ns/1ps
module pdf_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [pdf_pkg::CHAN_N-1:0] gpio_level,
    input wire logic out_pin_a0,
    input wire logic [pdf_pkg::CHAN_N-1:0] pwm_pin_owned,
    input wire logic pwm_irq_req,
    input wire logic ext0_fault_irq,
    input wire logic global_irq_enable
);
    import pdf_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    AST_RD_SLOT: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    AST_MODE_RB: assert property (reg_wr && reg_addr == A_MODE ##1 reg_rd && reg_addr == A_MODE
        |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 2)) else $error("mode readback wrong");
    // reserved select bits must never read back as set
    AST_SEL_RB: assert property (reg_wr && reg_addr == A_PINSEL ##1 reg_rd && reg_addr == A_PINSEL
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h33)) else $error("select readback wrong");
    AST_SEL_OFF: assert property (reg_wr && reg_addr == A_PINSEL && !reg_wdata[0]
        |=> ##[0:1] !pwm_pin_owned[0]) else $error("pin kept after deselect");
    AST_RUN_OFF: assert property (reg_wr && reg_addr == A_MODE && !reg_wdata[7]
        |=> ##[0:1] pwm_pin_owned == 4'h0) else $error("pins kept after stop");
    AST_GPIO: assert property (!pwm_pin_owned[0] |=> out_pin_a0 == $past(gpio_level[0]))
        else $error("free pin does not follow gpio");
    // writes are excluded for two cycles because enables land one cycle late
    AST_OVF_HOLD: assert property (pwm_irq_req && !reg_wr && !$past(reg_wr) |=> pwm_irq_req)
        else $error("overflow request dropped by itself");
    AST_FLT_HOLD: assert property (ext0_fault_irq && !reg_wr && !$past(reg_wr) |=> ext0_fault_irq)
        else $error("fault request dropped by itself");
    AST_GIE: assert property (reg_wr && reg_addr == A_IEN0 && reg_wdata[7]
        |=> ##[0:1] global_irq_enable) else $error("global enable not set");
endmodule
bind pdf_top pdf_chk u_chk (.*);

// ---- bench/test_pwm_dead_band_fail_detect.sv ----
// testbench: registers, waveform, one pulse and fault of the pwm timer
`timescale 1ns/1ps
module test_pwm_dead_band_fail_detect;
    import pdf_pkg::*;
    logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, fault_input_pin = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic [3:0] gpio_level = 4'h0, owned, o_d;
    logic out_pin_a0, a1, b0, b1, idle_wake, ext0_fault_irq;
    logic [31:0] rq[$], wq[$];
    int fail_count = 0, check_count = 0, seed = 34798, gap = 0, hi = 0;
    logic [7:0] regs[14] = '{A_PER_H, A_PER_L, A_DUTY_H, A_DUTY_L, A_DBW_H, A_DBW_L, A_DBN, A_PINSEL, A_MODE,
        A_FAULT, A_IEN0, A_IRQ_ENABLE_SECOND, A_IRQ2, 8'h00};
    pdf_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_level(gpio_level), .fault_input_pin(fault_input_pin),
        .out_pin_a0(out_pin_a0), .out_pin_a1(a1), .out_pin_b0(b0), .out_pin_b1(b1), .pwm_pin_owned(owned),
        .pwm_irq_req(), .idle_wake(idle_wake), .ext0_fault_irq(ext0_fault_irq), .global_irq_enable());
    always #12.5 clock = ~clock;
    always @(posedge clock) gpio_level <= 4'($random(seed));
    // ------------------------------------------------
    // tasks and scoreboard
    // ------------------------------------------------
    task automatic summarize();
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // strobes are never lowered here, so accesses run back to back without a double drive
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back({24'h0, e});
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic wait_on(input bit f);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (2000) begin
            @(negedge clock);
            if ((f ? ext0_fault_irq : idle_wake) === 1'b1) return;
        end
        chk("wait bound", 32'h0, 32'h1);
        summarize();
    endtask
    // the first period after a change is partial, so only the third wake is judged
    task automatic row(input logic [2:0] c, input logic [7:0] p, d, n, w, input logic inv, input int h);
        int dv;
        dv = 128 >> c;
        bus(1'b1, 1'b0, A_PER_L, p);
        bus(1'b1, 1'b0, A_DUTY_L, d);
        bus(1'b1, 1'b0, A_DBN, n);
        bus(1'b1, 1'b0, A_DBW_L, w);
        bus(1'b1, 1'b0, A_MODE, {1'b1, c, inv, inv, 2'b00});
        wait_on(1'b0);
        wait_on(1'b0);
        @(posedge clock);
        wq.push_back({16'(p * dv), 16'(h * dv)});
        wait_on(1'b0);
    endtask
    always @(posedge clock) rd_d <= reg_rd;
    always @(negedge clock) begin
        gap++;
        hi += int'(out_pin_a0 === 1'b1);
        // pins lag ownership by one cycle, so judge only after a full owned cycle
        if (o_d === 4'hF) chk("pin group", {29'h0, a1, b0, b1}, {29'h0, {3{out_pin_a0}}});
        o_d = owned;
        if (rd_d) chk("read data", {24'h0, reg_rdata}, rq.pop_front());
        if (idle_wake === 1'b1) begin
            if (wq.size() > 0) chk("period and high time", {gap[15:0], hi[15:0]}, wq.pop_front());
            gap = 0;
            hi = 0;
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (int i = 0; i < 9; i++) begin
            v = 8'($random(seed)) & (i == 8 ? 8'h7F : 8'hFF);
            bus(1'b1, 1'b0, regs[i], v);
            rd(regs[i], v & (i == 7 ? 8'h33 : 8'hFF));
        end
        for (int i = 0; i < 9; i++) bus(1'b1, 1'b0, regs[i], 8'h00);
        bus(1'b1, 1'b0, A_PINSEL, 8'h33);
        bus(1'b1, 1'b0, A_IRQ_ENABLE_SECOND, 8'h08);
        for (int c = 0; c < 8; c++) row(3'(c), 8'h03, 8'h01, 8'h00, 8'h00, 1'b0, 1);
        row(3'h7, 8'h08, 8'h03, 8'h00, 8'h00, 1'b0, 3);
        row(3'h7, 8'h08, 8'h03, 8'h00, 8'h00, 1'b1, 5);
        row(3'h7, 8'h08, 8'h05, 8'h01, 8'h01, 1'b0, 3);
        row(3'h7, 8'h08, 8'h03, 8'h00, 8'h04, 1'b0, 0);
        bus(1'b1, 1'b0, A_PINSEL, 8'h00);
        bus(1'b1, 1'b0, A_MODE, 8'h00);
        bus(1'b1, 1'b0, A_IRQ2, 8'h00);
        bus(1'b1, 1'b0, A_IRQ2, 8'h08);
        rd(A_IRQ2, 8'h00);
        bus(1'b1, 1'b0, A_MODE, 8'hF1);
        wait_on(1'b0);
        rd(A_MODE, 8'h71);
        rd(A_IRQ2, 8'h08);
        bus(1'b1, 1'b0, A_IRQ2, 8'h00);
        bus(1'b1, 1'b0, A_MODE, 8'hF1);
        wait_on(1'b0);
        rd(A_IRQ2, 8'h08);
        bus(1'b1, 1'b0, A_PER_L, 8'h00);
        bus(1'b1, 1'b0, A_MODE, 8'hF0);
        repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
        rd(A_MODE, 8'h70);
        bus(1'b1, 1'b0, A_PER_L, 8'h08);
        bus(1'b1, 1'b0, A_IEN0, 8'h81);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, 1'b0, A_EDGE, 8'(e));
            bus(1'b1, 1'b0, A_FAULT, 8'h01);
            bus(1'b1, 1'b0, A_MODE, 8'hF0);
            fault_input_pin <= ~fault_input_pin;
            wait_on(1'b1);
            rd(A_FAULT, 8'h03);
            rd(A_MODE, 8'h70);
            bus(1'b1, 1'b0, A_FAULT, 8'h03);
            rd(A_FAULT, 8'h03);
            bus(1'b1, 1'b0, A_FAULT, 8'h00);
            rd(A_FAULT, 8'h00);
        end
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        @(posedge clock);
        summarize();
    end
endmodule

// ---- design/pdf_pkg.sv ----
// package: register map, field positions and constants of the pwm unit
//
// Functional notes
// - one 16-bit up counter, clears at period, interrupts
// - overflow flag set on reaching period, readable
// - counter clock is oscillator divided 1..128
// - divider code 000 is /128, 111 is /1
// - output high when counting starts or restarts
// - output low when counter equals duty
// - overflow reloads zero, output high, period repeats
// - channel select plus sync switches pin to pwm
// - cleared select returns pin to gpio level
// - run enable needed; zero returns pins to gpio
// - single-pulse select gives one pulse, else continuous
// - single pulse overflow sets flag, clears run
// - per-group invert control on output pins
// - dead band inside high pulse, narrow and wide
// - dead band longer than duty gives no pulse
// - fault detect enable arms edge on fault pin
// - fault sets flag and clears run together
// - fault flag cleared by software only
// - fault interrupt needs ext0 enable and fault enable
// - pwm interrupt gated by enable, wakes idle
// - writing one to overflow flag does nothing
// - zero period at run enable stops the unit
package pdf_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 7;
    localparam int CHAN_N = 4;
    // register byte addresses
    localparam logic [7:0] A_MODE = 8'hAB;
    localparam logic [7:0] A_PINSEL = 8'hBE;
    localparam logic [7:0] A_PER_H = 8'hAD;
    localparam logic [7:0] A_PER_L = 8'hAC;
    localparam logic [7:0] A_DUTY_H = 8'hBC;
    localparam logic [7:0] A_DUTY_L = 8'hBB;
    localparam logic [7:0] A_DBW_H = 8'hAF;
    localparam logic [7:0] A_DBW_L = 8'hAE;
    localparam logic [7:0] A_DBN = 8'hBD;
    localparam logic [7:0] A_FAULT = 8'hB7;
    localparam logic [7:0] A_IEN0 = 8'hA8;
    localparam logic [7:0] A_IRQ_ENABLE_SECOND = 8'h9A;
    localparam logic [7:0] A_IRQ2 = 8'hBF;
    localparam logic [7:0] A_EDGE = 8'hB6;
    // field positions
    localparam int B_RUN = 7;
    localparam int B_DIV = 4;
    localparam int B_INV2 = 3;
    localparam int B_INV1 = 2;
    localparam int B_MODE_RSV = 1;
    localparam int B_ONE = 0;
    localparam int B_CH_A0 = 0;
    localparam int B_CH_A1 = 1;
    localparam int B_CH_B0 = 4;
    localparam int B_CH_B1 = 5;
    localparam int B_FFLAG = 1;
    localparam int B_FEN = 0;
    localparam int B_GIE = 7;
    localparam int B_EX0 = 0;
    localparam int B_PIRQ = 3;
    localparam int B_EDGE = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] DIV_ONE = 8'h01;
    localparam logic [2:0] DIV_MAX_CODE = 3'h7;
    typedef enum logic [1:0] {
        PDF_EDGE_FALL = 2'b00,
        PDF_EDGE_RISE = 2'b01,
        PDF_EDGE_ANY = 2'b10,
        PDF_EDGE_ANY2 = 2'b11
    } pdf_edge_e;
endpackage

// ---- design/pdf_prescaler.sv ----
// module: oscillator divider giving one-cycle count enables
`timescale 1ns/1ps
module pdf_prescaler #(
    parameter int PRE_WIDTH = pdf_pkg::PRE_W
) (
    input wire logic clock,
    input wire logic rst,
    pdf_tick_if.pre tk
);
    import pdf_pkg::*;

    logic [PRE_WIDTH-1:0] pre_r, pre_nxt;
    logic tick_r, tick_nxt;

    // last count value for a divider code
    function automatic logic [PRE_WIDTH-1:0] last_count(input logic [2:0] sel);
        logic [7:0] d;
        d = DIV_ONE << (DIV_MAX_CODE - sel);
        last_count = PRE_WIDTH'(d - DIV_ONE);
    endfunction

    always_comb begin
        pre_nxt = '0;
        tick_nxt = 1'b0;
        if (tk.run) begin
            // >= so a code change mid-count never waits a full wrap
            if (pre_r >= last_count(tk.sel)) begin
                tick_nxt = 1'b1;
            end else begin
                pre_nxt = PRE_WIDTH'(pre_r + 1'b1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_r <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule

// ---- design/pdf_tick_if.sv ----
// interface: run, divider code and count tick between core and prescaler
`timescale 1ns/1ps
interface pdf_tick_if;
    logic run;
    logic [2:0] sel;
    logic tick;
    modport pre (input run, input sel, output tick);
    modport core (output run, output sel, input tick);
endinterface

// ---- design/pdf_top.sv ----
// module: 16-bit pwm timer with dead band, one pulse and fault detect
`timescale 1ns/1ps
module pdf_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [pdf_pkg::CHAN_N-1:0] gpio_level,
    input wire logic fault_input_pin,
    output logic out_pin_a0,
    output logic out_pin_a1,
    output logic out_pin_b0,
    output logic out_pin_b1,
    output logic [pdf_pkg::CHAN_N-1:0] pwm_pin_owned,
    output logic pwm_irq_req,
    output logic idle_wake,
    output logic ext0_fault_irq,
    output logic global_irq_enable
);
    import pdf_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic run_enable_r, run_enable_nxt;
    logic [2:0] clock_divider_select_r, clock_divider_select_nxt;
    logic invert_group_one_r, invert_group_one_nxt;
    logic invert_group_two_r, invert_group_two_nxt;
    logic mode_spare_r, mode_spare_nxt;
    logic single_pulse_select_r, single_pulse_select_nxt;
    logic [CHAN_N-1:0] chan_sel_r, chan_sel_nxt;
    logic [CNT_W-1:0] period_value_r, period_value_nxt;
    logic [CNT_W-1:0] duty_value_r, duty_value_nxt;
    logic [CNT_W-1:0] deadband_wide_value_r, deadband_wide_value_nxt;
    logic [7:0] deadband_narrow_value_r, deadband_narrow_value_nxt;
    logic fault_detect_enable_r, fault_detect_enable_nxt;
    logic fault_flag_r, fault_flag_nxt;
    logic overflow_flag_r, overflow_flag_nxt;
    logic pwm_irq_enable_r, pwm_irq_enable_nxt;
    logic ext0_irq_enable_r, ext0_irq_enable_nxt;
    logic global_irq_enable_r, global_irq_enable_nxt;
    logic [1:0] ext0_edge_select_r, ext0_edge_select_nxt;

    logic [CNT_W-1:0] pwm_counter_r, pwm_counter_nxt;
    logic [CNT_W-1:0] period_act_r, period_act_nxt;
    logic active_r, active_nxt;
    logic ovf_evt, zero_stop_evt, cycle_start;

    logic [CHAN_N-1:0] owned_r, owned_nxt;
    logic [CHAN_N-1:0] pin_r, pin_nxt;
    logic wave_high;

    logic flt_s1_r, flt_s2_r, flt_s3_r, flt_lvl_r;
    logic flt_lvl_nxt, fault_evt_r, fault_evt_nxt;

    logic pwm_irq_req_r, pwm_irq_req_nxt;
    logic idle_wake_r, idle_wake_nxt;
    logic ext0_fault_irq_r, ext0_fault_irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    pdf_tick_if tk ();

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // window [narrow, duty - wide) of the high pulse after dead band
    function automatic logic in_high(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] duty,
        input logic [CNT_W-1:0] wide,
        input logic [7:0] narrow
    );
        logic [CNT_W-1:0] stop;
        stop = CNT_W'(duty - wide);
        in_high = 1'b0;
        // a dead band wider than the duty leaves nothing to drive
        if (wide <= duty) begin
            in_high = (cnt >= {8'h00, narrow}) && (cnt < stop);
        end
    endfunction

    function automatic logic [7:0] read_byte(input logic [7:0] addr);
        read_byte = ZERO_BYTE;
        unique case (addr)
            A_MODE: begin
                read_byte[B_RUN] = run_enable_r;
                read_byte[B_DIV +: 3] = clock_divider_select_r;
                read_byte[B_INV2] = invert_group_two_r;
                read_byte[B_INV1] = invert_group_one_r;
                read_byte[B_MODE_RSV] = mode_spare_r;
                read_byte[B_ONE] = single_pulse_select_r;
            end
            A_PINSEL: begin
                read_byte[B_CH_A0] = chan_sel_r[0];
                read_byte[B_CH_A1] = chan_sel_r[1];
                read_byte[B_CH_B0] = chan_sel_r[2];
                read_byte[B_CH_B1] = chan_sel_r[3];
            end
            A_PER_H: read_byte = period_value_r[15:8];
            A_PER_L: read_byte = period_value_r[7:0];
            A_DUTY_H: read_byte = duty_value_r[15:8];
            A_DUTY_L: read_byte = duty_value_r[7:0];
            A_DBW_H: read_byte = deadband_wide_value_r[15:8];
            A_DBW_L: read_byte = deadband_wide_value_r[7:0];
            A_DBN: read_byte = deadband_narrow_value_r;
            A_FAULT: begin
                read_byte[B_FFLAG] = fault_flag_r;
                read_byte[B_FEN] = fault_detect_enable_r;
            end
            A_IEN0: begin
                read_byte[B_GIE] = global_irq_enable_r;
                read_byte[B_EX0] = ext0_irq_enable_r;
            end
            A_IRQ_ENABLE_SECOND: read_byte[B_PIRQ] = pwm_irq_enable_r;
            A_IRQ2: read_byte[B_PIRQ] = overflow_flag_r;
            A_EDGE: read_byte[B_EDGE +: 2] = ext0_edge_select_r;
            default: read_byte = ZERO_BYTE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    assign tk.run = run_enable_r && active_r;
    assign tk.sel = clock_divider_select_r;

    pdf_prescaler #(.PRE_WIDTH(PRE_W)) u_pre (
        .clock(clock),
        .rst(rst),
        .tk(tk)
    );

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_comb begin
        pwm_counter_nxt = pwm_counter_r;
        period_act_nxt = period_act_r;
        active_nxt = active_r;
        ovf_evt = 1'b0;
        zero_stop_evt = 1'b0;
        cycle_start = 1'b0;
        if (!run_enable_r) begin
            pwm_counter_nxt = CNT_ZERO;
            active_nxt = 1'b0;
        end else if (!active_r) begin
            if (period_value_r == CNT_ZERO) begin
                zero_stop_evt = 1'b1;
            end else begin
                period_act_nxt = period_value_r;
                active_nxt = 1'b1;
                pwm_counter_nxt = CNT_ZERO;
            end
        end else if (tk.tick) begin
            cycle_start = (pwm_counter_r == CNT_ZERO);
            if (pwm_counter_r == CNT_W'(period_act_r - CNT_ONE)) begin
                ovf_evt = 1'b1;
                pwm_counter_nxt = CNT_ZERO;
                // a zero period is never taken into the running cycle
                if (period_value_r != CNT_ZERO) begin
                    period_act_nxt = period_value_r;
                end
            end else begin
                pwm_counter_nxt = CNT_W'(pwm_counter_r + CNT_ONE);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_counter_r <= CNT_ZERO;
            period_act_r <= CNT_ZERO;
            active_r <= 1'b0;
        end else begin
            pwm_counter_r <= pwm_counter_nxt;
            period_act_r <= period_act_nxt;
            active_r <= active_nxt;
        end
    end

    // ----------------------------------------------------------------
    // fault pin synchroniser and edge
    // ----------------------------------------------------------------
    always_comb begin
        flt_lvl_nxt = flt_lvl_r;
        if (flt_s2_r == flt_s3_r) begin
            flt_lvl_nxt = flt_s3_r;
        end
        fault_evt_nxt = 1'b0;
        if (fault_detect_enable_r && (flt_lvl_nxt != flt_lvl_r)) begin
            unique case (pdf_edge_e'(ext0_edge_select_r))
                PDF_EDGE_FALL: fault_evt_nxt = !flt_lvl_nxt;
                PDF_EDGE_RISE: fault_evt_nxt = flt_lvl_nxt;
                PDF_EDGE_ANY: fault_evt_nxt = 1'b1;
                PDF_EDGE_ANY2: fault_evt_nxt = 1'b1;
            endcase
        end
    end

    // idle level high, so a held-low pin gives one event after release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flt_s1_r <= 1'b1;
            flt_s2_r <= 1'b1;
            flt_s3_r <= 1'b1;
            flt_lvl_r <= 1'b1;
            fault_evt_r <= 1'b0;
        end else begin
            flt_s1_r <= fault_input_pin;
            flt_s2_r <= flt_s1_r;
            flt_s3_r <= flt_s2_r;
            flt_lvl_r <= flt_lvl_nxt;
            fault_evt_r <= fault_evt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb begin
        run_enable_nxt = run_enable_r;
        clock_divider_select_nxt = clock_divider_select_r;
        invert_group_one_nxt = invert_group_one_r;
        invert_group_two_nxt = invert_group_two_r;
        mode_spare_nxt = mode_spare_r;
        single_pulse_select_nxt = single_pulse_select_r;
        chan_sel_nxt = chan_sel_r;
        period_value_nxt = period_value_r;
        duty_value_nxt = duty_value_r;
        deadband_wide_value_nxt = deadband_wide_value_r;
        deadband_narrow_value_nxt = deadband_narrow_value_r;
        fault_detect_enable_nxt = fault_detect_enable_r;
        fault_flag_nxt = fault_flag_r;
        overflow_flag_nxt = overflow_flag_r;
        pwm_irq_enable_nxt = pwm_irq_enable_r;
        ext0_irq_enable_nxt = ext0_irq_enable_r;
        global_irq_enable_nxt = global_irq_enable_r;
        ext0_edge_select_nxt = ext0_edge_select_r;
        if (zero_stop_evt) begin
            run_enable_nxt = 1'b0;
        end
        if (ovf_evt && single_pulse_select_r) begin
            run_enable_nxt = 1'b0;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                A_MODE: begin
                    run_enable_nxt = reg_wdata[B_RUN];
                    clock_divider_select_nxt = reg_wdata[B_DIV +: 3];
                    invert_group_two_nxt = reg_wdata[B_INV2];
                    invert_group_one_nxt = reg_wdata[B_INV1];
                    mode_spare_nxt = reg_wdata[B_MODE_RSV];
                    single_pulse_select_nxt = reg_wdata[B_ONE];
                end
                A_PINSEL: begin
                    chan_sel_nxt = {reg_wdata[B_CH_B1], reg_wdata[B_CH_B0],
                                    reg_wdata[B_CH_A1], reg_wdata[B_CH_A0]};
                end
                A_PER_H: period_value_nxt[15:8] = reg_wdata;
                A_PER_L: period_value_nxt[7:0] = reg_wdata;
                A_DUTY_H: duty_value_nxt[15:8] = reg_wdata;
                A_DUTY_L: duty_value_nxt[7:0] = reg_wdata;
                A_DBW_H: deadband_wide_value_nxt[15:8] = reg_wdata;
                A_DBW_L: deadband_wide_value_nxt[7:0] = reg_wdata;
                A_DBN: deadband_narrow_value_nxt = reg_wdata;
                A_FAULT: begin
                    fault_detect_enable_nxt = reg_wdata[B_FEN];
                    if (!reg_wdata[B_FFLAG]) begin
                        fault_flag_nxt = 1'b0;
                    end
                end
                A_IEN0: begin
                    global_irq_enable_nxt = reg_wdata[B_GIE];
                    ext0_irq_enable_nxt = reg_wdata[B_EX0];
                end
                A_IRQ_ENABLE_SECOND: pwm_irq_enable_nxt = reg_wdata[B_PIRQ];
                A_IRQ2: begin
                    // a one written here is ignored: clear only
                    if (!reg_wdata[B_PIRQ]) begin
                        overflow_flag_nxt = 1'b0;
                    end
                end
                A_EDGE: ext0_edge_select_nxt = reg_wdata[B_EDGE +: 2];
                default: begin
                end
            endcase
        end
        // hardware sets win over a software clear in the same cycle
        if (ovf_evt) begin
            overflow_flag_nxt = 1'b1;
        end
        if (fault_evt_r) begin
            fault_flag_nxt = 1'b1;
            run_enable_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_enable_r <= 1'b0;
            clock_divider_select_r <= 3'h0;
            invert_group_one_r <= 1'b0;
            invert_group_two_r <= 1'b0;
            mode_spare_r <= 1'b0;
            single_pulse_select_r <= 1'b0;
            chan_sel_r <= '0;
            period_value_r <= CNT_ZERO;
            duty_value_r <= CNT_ZERO;
            deadband_wide_value_r <= CNT_ZERO;
            deadband_narrow_value_r <= ZERO_BYTE;
            fault_detect_enable_r <= 1'b0;
            fault_flag_r <= 1'b0;
            overflow_flag_r <= 1'b0;
            pwm_irq_enable_r <= 1'b0;
            ext0_irq_enable_r <= 1'b0;
            global_irq_enable_r <= 1'b0;
            ext0_edge_select_r <= 2'h0;
        end else begin
            run_enable_r <= run_enable_nxt;
            clock_divider_select_r <= clock_divider_select_nxt;
            invert_group_one_r <= invert_group_one_nxt;
            invert_group_two_r <= invert_group_two_nxt;
            mode_spare_r <= mode_spare_nxt;
            single_pulse_select_r <= single_pulse_select_nxt;
            chan_sel_r <= chan_sel_nxt;
            period_value_r <= period_value_nxt;
            duty_value_r <= duty_value_nxt;
            deadband_wide_value_r <= deadband_wide_value_nxt;
            deadband_narrow_value_r <= deadband_narrow_value_nxt;
            fault_detect_enable_r <= fault_detect_enable_nxt;
            fault_flag_r <= fault_flag_nxt;
            overflow_flag_r <= overflow_flag_nxt;
            pwm_irq_enable_r <= pwm_irq_enable_nxt;
            ext0_irq_enable_r <= ext0_irq_enable_nxt;
            global_irq_enable_r <= global_irq_enable_nxt;
            ext0_edge_select_r <= ext0_edge_select_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pins, interrupt requests and read data
    // ----------------------------------------------------------------
    assign wave_high = in_high(pwm_counter_r, duty_value_r,
                               deadband_wide_value_r, deadband_narrow_value_r);

    always_comb begin
        owned_nxt = owned_r;
        pin_nxt = gpio_level;
        for (int i = 0; i < CHAN_N; i++) begin
            if (!run_enable_r || !chan_sel_r[i]) begin
                owned_nxt[i] = 1'b0;
            end else if (cycle_start) begin
                // hand over only on a cycle boundary to avoid a runt pulse
                owned_nxt[i] = 1'b1;
            end
            if (owned_r[i]) begin
                pin_nxt[i] = wave_high ^ ((i < 2) ? invert_group_one_r
                                                  : invert_group_two_r);
            end
        end
        pwm_irq_req_nxt = overflow_flag_r && pwm_irq_enable_r;
        idle_wake_nxt = ovf_evt && pwm_irq_enable_r;
        ext0_fault_irq_nxt = fault_flag_r && ext0_irq_enable_r && fault_detect_enable_r;
        rdata_nxt = reg_rd ? read_byte(reg_addr) : ZERO_BYTE;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            owned_r <= '0;
            pin_r <= '0;
            pwm_irq_req_r <= 1'b0;
            idle_wake_r <= 1'b0;
            ext0_fault_irq_r <= 1'b0;
            rdata_r <= ZERO_BYTE;
        end else begin
            owned_r <= owned_nxt;
            pin_r <= pin_nxt;
            pwm_irq_req_r <= pwm_irq_req_nxt;
            idle_wake_r <= idle_wake_nxt;
            ext0_fault_irq_r <= ext0_fault_irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign out_pin_a0 = pin_r[0];
    assign out_pin_a1 = pin_r[1];
    assign out_pin_b0 = pin_r[2];
    assign out_pin_b1 = pin_r[3];
    assign pwm_pin_owned = owned_r;
    assign pwm_irq_req = pwm_irq_req_r;
    assign idle_wake = idle_wake_r;
    assign ext0_fault_irq = ext0_fault_irq_r;
    assign global_irq_enable = global_irq_enable_r;
    assign reg_rdata = rdata_r;
endmodule
